// [hw/rcw_pkg.sv]
// constants shared by the runaway code watchdog
package rcw_pkg;
  localparam logic [15:0] SERVICE_PORT_ADDR = 16'hffff;
  localparam int          PRESCALER_W       = 12;
  localparam int          GUARD_W           = 6;
  localparam int          SVC_CLR_LSB       = 4;      // stages 12..5 are bits 11..4
  localparam int          RESET_LOW_CYCLES  = 32;
  localparam int          POR_CLEAR_CYCLES  = 4096;
  localparam int          LONG_PERIOD       = 262128;
  localparam int          SHORT_PERIOD      = 8176;
  localparam int          CLK_HZ            = 20000000;
  // option latch bit positions and reset value
  localparam int          OPT_DISABLE_BIT   = 0;
  localparam int          OPT_RATE_BIT      = 1;
  localparam int          OPT_STOP_EN_BIT   = 2;
  localparam logic [2:0]  OPT_RESET         = 3'h0;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam int          STATUS_GUARD_BIT  = 0;
  localparam int          STATUS_ILLOP_BIT  = 1;
  typedef enum logic [2:0] {
    RCW_RUN   = 3'b001,
    RCW_RESET = 3'b010,
    RCW_HALT  = 3'b100
  } rcw_state_e;
endpackage

// [hw/rcw_sync3.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rcw_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       dout_reg;
  logic       dout_next;

  // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
  always_comb begin
    stage_next = {stage_reg[1:0], din};
    dout_next  = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : dout_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= 3'h0;
      dout_reg  <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      dout_reg  <= dout_next;
    end
  end

  assign dout = dout_reg;
endmodule

// [hw/rcw_runaway_code_watchdog.sv]
// runaway code watchdog: prescaler, guard counter, reset pulse and status
// What this block does
// - 6-bit free-running guard counter clocked from a 12-bit crystal prescaler.
// - guard overflow after 262128 or 8176 crystal cycles raises a reset.
// - a write to FFFF clears prescaler stages 12 to 5 and, outside stop mode, the guard counter.
// - guard reset drives reset pin low 32 cycles and sets cause flag.
// - monitor entry with test voltage on irq disables guard while voltage stays.
// - monitor entry from blank vectors disables guard until next power-on reset.
// - during break, test voltage on reset pin disables the guard.
// - stop mode halts guard clocking and clears the prescaler.
// - reading FFFF returns the reset vector low byte, not guard state.
// - power-on logic clears prescaler 4096 crystal cycles after power-up.
// - any internal reset clears prescaler and guard counter.
// - guard enable follows write-once disable option; set means no reset.
// - the guard never raises a cpu interrupt, only resets.
// - guard keeps counting in wait mode and resets on timeout.
// - stop with stop option clear gives illegal opcode reset instead.
// - rate select set gives 8176 cycles, clear gives 262128 cycles.
// - disable bit one disables the guard, zero enables it.
// - every reset clears option bits: enabled, long period.
`timescale 1ns/1ps
module rcw_runaway_code_watchdog #(
  parameter int          POR_CYCLES = rcw_pkg::POR_CLEAR_CYCLES,
  parameter logic [7:0]  VECTOR_LOW = 8'h00   // reset vector low byte, arbitrary
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        opt_wr,
  input  wire logic [2:0]  opt_wdata,
  input  wire logic        status_rd,
  output logic      [7:0]  reset_status_register,
  input  wire logic        stop_exec,
  input  wire logic        wait_mode,
  input  wire logic        monitor_entry,
  input  wire logic        monitor_blank_vectors,
  input  wire logic        break_active,
  input  wire logic        irq_test_voltage_level,
  input  wire logic        rst_test_voltage_level,
  input  wire logic        stop_wake,
  output logic             reset_pin_n,
  output logic             reset_pin_oe,
  output logic             stop_active,
  output logic [2:0]       option_latch
);
  localparam int CNT_W = $clog2(rcw_pkg::RESET_LOW_CYCLES + 1);
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  // prescaler tap and terminal values: overflow lands 16 crystal cycles ahead
  // of the 64th guard tick, so the totals are 2^18-16 and 2^13-16
  localparam logic [11:0] LONG_TAP   = 12'hfff;
  localparam logic [11:0] LONG_TERM  = 12'hfef;
  localparam logic [6:0]  SHORT_TAP  = 7'h7f;
  localparam logic [6:0]  SHORT_TERM = 7'h6f;

  //////////////////////////////////////////////////////////////////////////
  // synchronise the test voltage detectors, they come from pins
  logic irq_tv;
  logic rst_tv;

  rcw_sync3 u_sync_irq (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (irq_test_voltage_level),
    .dout    (irq_tv)
  );

  rcw_sync3 u_sync_rst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (rst_test_voltage_level),
    .dout    (rst_tv)
  );

  //////////////////////////////////////////////////////////////////////////
  // state
  rcw_pkg::rcw_state_e            state_reg, state_next;
  logic [rcw_pkg::PRESCALER_W-1:0] presc_reg, presc_next;
  logic [rcw_pkg::GUARD_W-1:0]     guard_reg, guard_next;
  logic [CNT_W-1:0]                low_cnt_reg, low_cnt_next;
  logic [POR_W-1:0]                por_cnt_reg, por_cnt_next;
  logic                            por_done_reg, por_done_next;
  logic [2:0]                      opt_reg, opt_next;
  logic                            opt_locked_reg, opt_locked_next;
  logic [7:0]                      status_reg, status_next;
  logic [7:0]                      rdata_reg, rdata_next;
  logic                            mon_tv_reg, mon_tv_next;
  logic                            mon_blank_reg, mon_blank_next;
  logic                            pin_n_reg, pin_n_next;
  logic                            pin_oe_reg, pin_oe_next;
  logic                            stop_reg, stop_next;

  logic service;
  logic guard_en;
  logic guard_tick;
  logic overflow;
  logic illop;
  logic int_reset;
  logic presc_tap;

  //////////////////////////////////////////////////////////////////////////
  // enables and events
  always_comb begin
    service    = bus_wr && (bus_addr == rcw_pkg::SERVICE_PORT_ADDR);
    illop      = stop_exec && !opt_reg[rcw_pkg::OPT_STOP_EN_BIT];
    // guard steps once per 2^7 or 2^12 crystal cycles
    presc_tap  = opt_reg[rcw_pkg::OPT_RATE_BIT]
                 ? (presc_reg[6:0] == SHORT_TAP)
                 : (presc_reg == LONG_TAP);
    guard_tick = (state_reg == rcw_pkg::RCW_RUN) && por_done_reg && presc_tap;
    guard_en   = !opt_reg[rcw_pkg::OPT_DISABLE_BIT]
                 && !(mon_tv_reg && (irq_tv || rst_tv))
                 && !mon_blank_reg
                 && !(break_active && rst_tv);
    // a held or disabled guard keeps counting; only its overflow is masked
    // last guard value plus terminal prescaler value marks the timeout
    overflow   = (state_reg == rcw_pkg::RCW_RUN) && guard_en
                 && (guard_reg == 6'h3f)
                 && (opt_reg[rcw_pkg::OPT_RATE_BIT]
                     ? (presc_reg[6:0] == SHORT_TERM)
                     : (presc_reg == LONG_TERM));
    int_reset  = overflow || illop;
  end

  //////////////////////////////////////////////////////////////////////////
  // counters, stop handling and reset pulse sequencing
  always_comb begin
    state_next    = state_reg;
    presc_next    = presc_reg + 12'h001;
    guard_next    = guard_reg + {5'h00, guard_tick};
    low_cnt_next  = low_cnt_reg;
    pin_n_next    = 1'b1;
    pin_oe_next   = 1'b0;
    por_cnt_next  = por_cnt_reg;
    por_done_next = por_done_reg;
    if (!por_done_reg) begin
      por_cnt_next = por_cnt_reg + {{(POR_W-1){1'b0}}, 1'b1};
      if (por_cnt_reg == POR_W'(POR_CYCLES - 1)) begin
        por_done_next = 1'b1;
        presc_next    = '0;
      end
    end
    if (service) begin
      presc_next[rcw_pkg::PRESCALER_W-1:rcw_pkg::SVC_CLR_LSB] = '0;
      guard_next = '0;
    end
    case (state_reg)
      rcw_pkg::RCW_RUN: begin
        if (int_reset) begin
          state_next   = rcw_pkg::RCW_RESET;
          low_cnt_next = '0;
          presc_next   = '0;
          guard_next   = '0;
        end else if (stop_exec) begin
          state_next = rcw_pkg::RCW_HALT;
          presc_next = '0;
        end
      end
      rcw_pkg::RCW_RESET: begin
        pin_n_next   = 1'b0;
        pin_oe_next  = 1'b1;
        presc_next   = '0;
        guard_next   = '0;
        low_cnt_next = low_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        // pin falls one edge after entry, so release once 32 lows are counted
        if (low_cnt_reg == CNT_W'(rcw_pkg::RESET_LOW_CYCLES)) begin
          state_next  = rcw_pkg::RCW_RUN;
          pin_n_next  = 1'b1;
          pin_oe_next = 1'b0;
        end
      end
      rcw_pkg::RCW_HALT: begin
        presc_next = '0;
        guard_next = guard_reg;
        if (stop_wake) begin
          state_next = rcw_pkg::RCW_RUN;
        end
      end
      default: begin
        state_next = rcw_pkg::RCW_RUN;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // option latch and monitor latches
  always_comb begin
    opt_next        = opt_reg;
    opt_locked_next = opt_locked_reg;
    mon_tv_next     = mon_tv_reg;
    mon_blank_next  = mon_blank_reg;
    // write-once: later writes are dropped until the next reset
    if (opt_wr && !opt_locked_reg) begin
      opt_next        = opt_wdata;
      opt_locked_next = 1'b1;
    end
    if (monitor_entry) begin
      mon_tv_next = irq_tv;
      if (monitor_blank_vectors && !irq_tv) begin
        mon_blank_next = 1'b1;
      end
    end
    // the hold ends once neither pin carries the test voltage
    if (mon_tv_reg && !irq_tv && !rst_tv) begin
      mon_tv_next = 1'b0;
    end
    // an internal reset rearms the latch with guard on and long period
    if (state_reg == rcw_pkg::RCW_RESET) begin
      opt_next        = rcw_pkg::OPT_RESET;
      opt_locked_next = 1'b0;
    end
  end

  // rst_n stands for power-on reset; only it clears the blank-vector latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opt_reg        <= rcw_pkg::OPT_RESET;
      opt_locked_reg <= 1'b0;
      mon_tv_reg     <= 1'b0;
      mon_blank_reg  <= 1'b0;
    end else begin
      opt_reg        <= opt_next;
      opt_locked_reg <= opt_locked_next;
      mon_tv_reg     <= mon_tv_next;
      mon_blank_reg  <= mon_blank_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset status, read data and stop flag
  always_comb begin
    status_next = status_reg;
    rdata_next  = rdata_reg;
    // registered copy of the halt state so the output comes from a flop
    stop_next   = (state_next == rcw_pkg::RCW_HALT);
    if (status_rd) begin
      status_next = rcw_pkg::STATUS_RESET;
    end
    // a cause arriving in the read cycle wins over the clear
    if (overflow) begin
      status_next[rcw_pkg::STATUS_GUARD_BIT] = 1'b1;
    end
    if (illop) begin
      status_next[rcw_pkg::STATUS_ILLOP_BIT] = 1'b1;
    end
    // the service port overlaps the vector, so reads never show guard state
    if (bus_rd && (bus_addr == rcw_pkg::SERVICE_PORT_ADDR)) begin
      rdata_next = VECTOR_LOW;
    end else if (bus_rd) begin
      rdata_next = 8'h00;
    end
  end

  // status survives internal resets so software can tell what happened
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= rcw_pkg::STATUS_RESET;
      rdata_reg  <= 8'h00;
      stop_reg   <= 1'b0;
    end else begin
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
      stop_reg   <= stop_next;
    end
  end

  // counters, sequencer and reset pin
  // the pin pair shares this reset so it idles released after power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= rcw_pkg::RCW_RUN;
      presc_reg    <= '0;
      guard_reg    <= '0;
      low_cnt_reg  <= '0;
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
      pin_n_reg    <= 1'b1;
      pin_oe_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      presc_reg    <= presc_next;
      guard_reg    <= guard_next;
      low_cnt_reg  <= low_cnt_next;
      por_cnt_reg  <= por_cnt_next;
      por_done_reg <= por_done_next;
      pin_n_reg    <= pin_n_next;
      pin_oe_reg   <= pin_oe_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign bus_rdata             = rdata_reg;
  assign reset_status_register = status_reg;
  assign reset_pin_n           = pin_n_reg;
  assign reset_pin_oe          = pin_oe_reg;
  assign stop_active           = stop_reg;
  assign option_latch          = opt_reg;
endmodule

// [dv/rcw_chk_sva.sv]
// port checker for the runaway code watchdog
`timescale 1ns/1ps
module rcw_chk #(
  parameter logic [7:0] VECTOR_LOW = 8'h00
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        status_rd,
  input wire logic [7:0]  reset_status_register,
  input wire logic        reset_pin_n,
  input wire logic        reset_pin_oe,
  input wire logic        stop_active,
  input wire logic [2:0]  option_latch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [5:0]  low_reg;
  logic [5:0]  low_next;
  logic [13:0] svc_reg;
  logic [13:0] svc_next;
  //////////////////////////////////////////////////////////////////
  // low-pulse length and cycles since service, the latter saturating
  always_comb begin
    low_next = reset_pin_n ? 6'h00 : low_reg + 6'h01;
    svc_next = (bus_wr && bus_addr == 16'hffff) ? 14'h0000 : svc_reg + {13'h0000, ~&svc_reg};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_reg <= 6'h00;
      svc_reg <= 14'h0000;
    end else begin
      low_reg <= low_next;
      svc_reg <= svc_next;
    end
  end
  //////////////////////////////////////////////////////////////////
  pulse_width_a: assert property ($rose(reset_pin_n) |-> low_reg == 6'h20)
    else $error("reset pulse not 32 cycles");
  pulse_bound_a: assert property (low_reg <= 6'h20)
    else $error("reset pulse too long");
  oe_follows_a: assert property (reset_pin_oe == !reset_pin_n)
    else $error("pin enable mismatch");
  cause_flag_a: assert property ($fell(reset_pin_n) |->
    (|reset_status_register[1:0]) && option_latch == 3'h0) else $error("cause or options");
  service_gap_a: assert property ($fell(reset_pin_n) && reset_status_register[0] |->
    svc_reg >= 14'h1fe0) else $error("timeout too soon after service");
  vector_read_a: assert property (bus_rd && bus_addr == 16'hffff |=> bus_rdata == VECTOR_LOW)
    else $error("service port read wrong");
  other_read_a: assert property (bus_rd && bus_addr != 16'hffff |=> bus_rdata == 8'h00)
    else $error("other read not zero");
  flag_hold_a: assert property (reset_status_register[0] && !status_rd |=>
    reset_status_register[0]) else $error("cause flag lost");
  stop_quiet_a: assert property (stop_active |-> reset_pin_n)
    else $error("reset while stopped");
endmodule
bind rcw_runaway_code_watchdog rcw_chk #(.VECTOR_LOW(VECTOR_LOW)) u_chk (.clk_sys, .rst_n,
  .bus_addr, .bus_wr, .bus_rd, .bus_rdata, .status_rd, .reset_status_register, .reset_pin_n,
  .reset_pin_oe, .stop_active, .option_latch);

// [dv/tb_top.sv]
// self-checking bench for the runaway code watchdog
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, rst_n, bus_wr, bus_rd, opt_wr, status_rd, stop_exec, stop_wake;
  logic        wait_mode, monitor_entry, monitor_blank_vectors, break_active;
  logic        irq_test_voltage_level, rst_test_voltage_level;
  logic        reset_pin_n, reset_pin_oe, stop_active;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, reset_status_register;
  logic [2:0]  opt_wdata, option_latch;
  int          fails = 0;
  int          checks_done = 0;
  int          k;
  rcw_runaway_code_watchdog #(.POR_CYCLES(8), .VECTOR_LOW(8'h5a)) DUT (.clk_sys, .rst_n,
    .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .opt_wr, .opt_wdata, .status_rd,
    .reset_status_register, .stop_exec, .wait_mode, .monitor_entry, .monitor_blank_vectors,
    .break_active, .irq_test_voltage_level, .rst_test_voltage_level, .stop_wake,
    .reset_pin_n, .reset_pin_oe, .stop_active, .option_latch);
  // 20 MHz crystal clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reset pulse, short power-on wait, then the one option write
  task automatic boot(input logic [2:0] opt);
    rst_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
    opt_wdata = opt;
    opt_wr = 1'b1;
    @(negedge clk_sys);
    opt_wr = 1'b0;
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = wr;
    bus_rd = !wr;
    @(negedge clk_sys);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  // bounded wait for the pin to drop; k stays -1 if it never does
  task automatic watch(input int n);
    k = -1;
    for (int i = 0; i < n && k < 0; i++) begin
      @(negedge clk_sys);
      if (reset_pin_n === 1'b0) k = i;
    end
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_read;
    boot(3'h0);
    chk("pin idle", 2'b01, {reset_pin_oe, reset_pin_n});
    bus(1'b0, 16'hffff, 8'h00);
    chk("vector", 8'h5a, bus_rdata);
    bus(1'b0, 16'hfffe, 8'h00);
    chk("other", 8'h00, bus_rdata);
    $display("t_read done");
  endtask
  task automatic t_timeout;
    int w;
    w = 0;
    boot(3'h2);
    wait_mode = 1'b1;
    bus(1'b1, 16'hffff, 8'ha5);
    watch(8300);
    chk("period", 1'b1, k >= 8150 && k <= 8180);
    chk("cause", 8'h01, reset_status_register);
    chk("options", 3'h0, option_latch);
    repeat (40) begin
      w += int'(!reset_pin_n);
      @(negedge clk_sys);
    end
    chk("low", 16'd32, w);
    chk("kept", 8'h01, reset_status_register);
    status_rd = 1'b1;
    @(negedge clk_sys);
    status_rd = 1'b0;
    @(negedge clk_sys);
    chk("cleared", 8'h00, reset_status_register);
    watch(9000);
    chk("restart", 16'hffff, k);
    wait_mode = 1'b0;
    $display("t_timeout done");
  endtask
  task automatic t_service;
    boot(3'h2);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 16'hffff, 8'(i * 85));
      watch(5000);
      chk("serviced", 16'hffff, k);
    end
    $display("t_service done");
  endtask
  // disable option, monitor with irq voltage, blank vectors, break
  task automatic t_off;
    for (int c = 0; c < 4; c++) begin
      boot(c == 0 ? 3'h3 : 3'h2);
      irq_test_voltage_level = (c == 1);
      monitor_blank_vectors = (c == 2);
      break_active = (c == 3);
      rst_test_voltage_level = (c == 3);
      repeat (6) @(negedge clk_sys);
      monitor_entry = (c == 1 || c == 2);
      @(negedge clk_sys);
      monitor_entry = 1'b0;
      watch(9000);
      chk("disabled", 16'hffff, k);
      {irq_test_voltage_level, monitor_blank_vectors, break_active} = 3'h0;
      rst_test_voltage_level = 1'b0;
    end
    $display("t_off done");
  endtask
  task automatic t_stop;
    boot(3'h6);
    stop_exec = 1'b1;
    @(negedge clk_sys);
    stop_exec = 1'b0;
    @(negedge clk_sys);
    chk("stopped", 1'b1, stop_active);
    watch(9000);
    chk("frozen", 16'hffff, k);
    stop_wake = 1'b1;
    @(negedge clk_sys);
    stop_wake = 1'b0;
    bus(1'b1, 16'hffff, 8'h3c);
    watch(8300);
    chk("resumed", 1'b1, k >= 8150 && k <= 8180);
    $display("t_stop done");
  endtask
  task automatic t_illop;
    boot(3'h2);
    stop_exec = 1'b1;
    @(negedge clk_sys);
    stop_exec = 1'b0;
    watch(4);
    chk("illop", 1'b1, k >= 0);
    chk("illop flag", 8'h02, reset_status_register);
    chk("not stopped", 1'b0, stop_active);
    $display("t_illop done");
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, bus_wr, bus_rd, opt_wr, status_rd, stop_exec, stop_wake, wait_mode} = 8'h00;
    {monitor_entry, monitor_blank_vectors, break_active} = 3'h0;
    {irq_test_voltage_level, rst_test_voltage_level} = 2'h0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    opt_wdata = 3'h0;
    t_read;
    t_timeout;
    t_service;
    t_off;
    t_stop;
    t_illop;
    final_report;
  end
  // hang guard
  initial begin
    repeat (100000) @(negedge clk_sys);
    fails++;
    final_report;
  end
endmodule
